// file: core/gpi_pkg.sv
/*
  Shared constants and types for the preset recall and fault alarm port:
  register map, field positions, reset values, timing and carriers.
  Assumes a single 200 MHz clock and an AXI4-Lite register master.
*/
package gpi_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_ALARM_CMD  = 8'h08;
   localparam logic [7:0] ADDR_FILTER_LEN = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_FAULT_EN_BIT = 0;
   localparam int CMD_RESET_BIT     = 0;
   localparam int CMD_REFRESH_BIT   = 1;
   localparam int ST_LATCHED_LSB    = 0;
   localparam int ST_VIEW_LSB       = 4;
   localparam int ST_LAST_LSB       = 8;
   localparam int ST_BUSY_BIT       = 12;
   localparam int ST_MODE_BIT       = 13;
   localparam int ST_INPUTS_LSB     = 16;
   localparam int IRQ_RECALL_BIT    = 0;
   localparam int IRQ_FAULT_BIT     = 1;

   // ****************************************************************
   // Reset values and codes
   // ****************************************************************
   localparam logic        FAULT_EN_RST   = 1'b0;
   localparam logic [15:0] FILTER_LEN_RST = 16'h0100;
   localparam logic [1:0]  IRQ_EN_RST     = 2'h0;
   localparam logic [2:0]  CODE_ALL_HIGH  = 3'h7;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
   localparam int unsigned RECALL_TIME_MS = 500;
   localparam int unsigned RECALL_CYCLES  =
      RECALL_TIME_MS * (CLK_FREQ_HZ / 1000);

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic fan_stopped;
      logic ref_absent;
      logic ref_unlocked;
      logic ref_drifting;
   } fault_s;

   typedef enum logic [2:0] {
      ALARM_NONE     = 3'h0,
      ALARM_DRIFTING = 3'h1,
      ALARM_UNLOCKED = 3'h2,
      ALARM_NO_REF   = 3'h3,
      ALARM_FAN      = 3'h4
   } alarm_code_e;

   typedef enum logic [1:0] {
      RECALL_IDLE = 2'b01,
      RECALL_WAIT = 2'b10
   } recall_e;

endpackage : gpi_pkg

// file: core/gpi_input_filter.sv
/*
  Synchroniser and stability filter for the three active-low preset
  select inputs. Assumes the raw pins may change at any time.
*/
`timescale 1ns/1ps
module gpi_input_filter
   import gpi_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_enable,
   input  wire logic [15:0] i_len,
   input  wire logic [2:0]  i_raw_n,
   output logic      [2:0]  o_stable_n
);

   typedef struct packed {
      logic [2:0]  meta;
      logic [2:0]  sync;
      logic [2:0]  cand;
      logic [15:0] cnt;
      logic [2:0]  stable;
   } filt_s;

   filt_s q;
   filt_s d;

   always_comb
   begin
      d      = q;
      d.meta = i_raw_n;
      d.sync = q.meta;
      if (!i_enable)
      begin
         // Idle pins look open so no recall can start
         d.cand   = CODE_ALL_HIGH;
         d.cnt    = 16'h0000;
         d.stable = CODE_ALL_HIGH;
      end
      else if (q.sync != q.cand)
      begin
         d.cand = q.sync;
         d.cnt  = 16'h0000;
      end
      else if (q.cnt < i_len)
      begin
         d.cnt = q.cnt + 16'h0001;
      end
      else
      begin
         d.stable = q.cand;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q <= '{meta: CODE_ALL_HIGH, sync: CODE_ALL_HIGH,
                cand: CODE_ALL_HIGH, cnt: 16'h0000,
                stable: CODE_ALL_HIGH};
      end
      else
      begin
         q <= d;
      end
   end

   assign o_stable_n = q.stable;

endmodule : gpi_input_filter

// file: core/gpi_preset_recall_alarm.sv
/*
  Preset recall decoder and latched fault alarm with an AXI4-Lite
  register slave. Assumes the fault inputs are synchronous levels
  and that the preset store acts on the recall strobe.
*/
`timescale 1ns/1ps
module gpi_preset_recall_alarm
   import gpi_pkg::*;
#(
   parameter int unsigned RECALL_CYC = RECALL_CYCLES
)
(
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   // Pin sharing and pins
   input  wire logic         i_general_purpose_input_port,
   input  wire logic [2:0]   i_preset_sel_n,
   output logic              o_alarm_n,
   input  wire gpi_pkg::fault_s i_faults,
   // Recall request to the preset store
   output logic              o_recall_strobe,
   output logic [2:0]        o_recall_preset,
   output logic              o_recall_busy,
   output logic              o_irq,
   // AXI4-Lite slave
   input  wire logic         i_s_axi_awvalid,
   output logic              o_s_axi_awready,
   input  wire logic [7:0]   i_s_axi_awaddr,
   input  wire logic         i_s_axi_wvalid,
   output logic              o_s_axi_wready,
   input  wire logic [31:0]  i_s_axi_wdata,
   input  wire logic [3:0]   i_s_axi_wstrb,
   output logic              o_s_axi_bvalid,
   input  wire logic         i_s_axi_bready,
   output logic [1:0]        o_s_axi_bresp,
   input  wire logic         i_s_axi_arvalid,
   output logic              o_s_axi_arready,
   input  wire logic [7:0]   i_s_axi_araddr,
   output logic              o_s_axi_rvalid,
   input  wire logic         i_s_axi_rready,
   output logic [31:0]       o_s_axi_rdata,
   output logic [1:0]        o_s_axi_rresp
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        fault_en;
      logic [15:0] filt_len;
      fault_s      latched;
      alarm_code_e view;
      logic [1:0]  irq_sts;
      logic [1:0]  irq_en;
      logic [2:0]  prev_n;
      recall_e     st;
      logic [31:0] cnt;
      logic [2:0]  pending;
      logic [2:0]  last;
      logic        strobe;
      logic        alarm_n;
      logic        busy;
      logic        irq;
   } regs_s;

   regs_s q;
   regs_s d;

   logic [2:0] stable_n;
   logic       mode;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [2:0] preset_of(input logic [2:0] code);
      // Pin one is the msb, low reads as one
      return 3'(CODE_ALL_HIGH - code);
   endfunction : preset_of

   function automatic alarm_code_e code_of(input fault_s f);
      // Worst condition wins when several are latched
      if (f.fan_stopped)       return ALARM_FAN;
      else if (f.ref_absent)   return ALARM_NO_REF;
      else if (f.ref_unlocked) return ALARM_UNLOCKED;
      else if (f.ref_drifting) return ALARM_DRIFTING;
      else                     return ALARM_NONE;
   endfunction : code_of

   // ****************************************************************
   // Input conditioning
   // ****************************************************************
   assign mode = i_general_purpose_input_port;

   gpi_input_filter u_filter (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_enable   (mode),
      .i_len      (q.filt_len),
      .i_raw_n    (i_preset_sel_n),
      .o_stable_n (stable_n)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic [7:0] wa;
      logic       cmd_reset;
      logic       cmd_refresh;
      logic [1:0] irq_clr;
      logic [1:0] irq_set;
      fault_s     set;
      logic       trig;

      d           = q;
      wa          = q.awaddr;
      cmd_reset   = 1'b0;
      cmd_refresh = 1'b0;
      irq_clr     = 2'h0;
      irq_set     = 2'h0;
      set         = '0;
      trig        = 1'b0;
      d.strobe    = 1'b0;

      // *********************************************************
      // Register writes
      // *********************************************************
      // Write channel: address and data may come in either order
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
         d.aw_got = 1'b1;
         d.awaddr = i_s_axi_awaddr;
         wa       = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
         d.w_got = 1'b1;
         d.wdata = i_s_axi_wdata;
         d.wstrb = i_s_axi_wstrb;
      end
      if (d.aw_got && d.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         if (wa == ADDR_CTRL)
         begin
            if (d.wstrb[0])
               d.fault_en = d.wdata[CTRL_FAULT_EN_BIT];
         end
         else if (wa == ADDR_ALARM_CMD)
         begin
            if (d.wstrb[0])
            begin
               cmd_reset   = d.wdata[CMD_RESET_BIT];
               cmd_refresh = d.wdata[CMD_REFRESH_BIT];
            end
         end
         else if (wa == ADDR_FILTER_LEN)
         begin
            if (d.wstrb[0])
               d.filt_len[7:0] = d.wdata[7:0];
            if (d.wstrb[1])
               d.filt_len[15:8] = d.wdata[15:8];
         end
         else if (wa == ADDR_IRQ_CLEAR)
         begin
            if (d.wstrb[0])
               irq_clr = d.wdata[1:0];
         end
         else if (wa == ADDR_IRQ_ENABLE)
         begin
            if (d.wstrb[0])
               d.irq_en = d.wdata[1:0];
         end
         else if (wa == ADDR_STATUS || wa == ADDR_IRQ_STATUS)
         begin
            d.bresp = RESP_OKAY;
         end
         else
         begin
            d.bresp = RESP_SLVERR;
         end
      end
      if (q.bvalid && i_s_axi_bready)
         d.bvalid = 1'b0;

      // *********************************************************
      // Register reads
      // *********************************************************
      // Read channel: one cycle from address to data
      if (i_s_axi_arvalid && o_s_axi_arready)
      begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         if (i_s_axi_araddr == ADDR_CTRL)
            d.rdata[CTRL_FAULT_EN_BIT] = q.fault_en;
         else if (i_s_axi_araddr == ADDR_STATUS)
         begin
            d.rdata[ST_LATCHED_LSB +: 4] = q.latched;
            d.rdata[ST_VIEW_LSB +: 3]    = q.view;
            d.rdata[ST_LAST_LSB +: 3]    = q.last;
            d.rdata[ST_BUSY_BIT]         = (q.st == RECALL_WAIT);
            d.rdata[ST_MODE_BIT]         = mode;
            d.rdata[ST_INPUTS_LSB +: 3]  = stable_n;
         end
         else if (i_s_axi_araddr == ADDR_FILTER_LEN)
            d.rdata[15:0] = q.filt_len;
         else if (i_s_axi_araddr == ADDR_IRQ_STATUS)
            d.rdata[1:0] = q.irq_sts;
         else if (i_s_axi_araddr == ADDR_IRQ_ENABLE)
            d.rdata[1:0] = q.irq_en;
         else if (i_s_axi_araddr == ADDR_ALARM_CMD ||
                  i_s_axi_araddr == ADDR_IRQ_CLEAR)
            d.rresp = RESP_OKAY;
         else
            d.rresp = RESP_SLVERR;
      end
      else if (q.rvalid && i_s_axi_rready)
      begin
         d.rvalid = 1'b0;
      end

      // *********************************************************
      // Fault latch and alarm pin
      // *********************************************************
      // Fault latch: a fault present in the clear cycle stays set
      if (mode)
         set = i_faults;
      if (cmd_reset)
         d.latched = set;
      else
         d.latched = q.latched | set;
      if ((set & ~q.latched) != '0)
         irq_set[IRQ_FAULT_BIT] = 1'b1;
      if (cmd_refresh)
         d.view = code_of(q.latched | set);

      // Alarm pin stays high unless enabled, shared and faulted
      d.alarm_n = ~(mode && q.fault_en &&
                    (d.latched != '0));

      // *********************************************************
      // Preset recall sequencer
      // *********************************************************
      // Recall: sampled levels only, so a glitch never reaches here
      d.prev_n = stable_n;
      trig = ((q.prev_n & ~stable_n) != 3'h0) &&
             (stable_n != CODE_ALL_HIGH) && mode;
      case (q.st)
         RECALL_IDLE:
         begin
            if (trig)
            begin
               d.pending = preset_of(stable_n);
               d.cnt     = 32'h0000_0001;
               d.st      = RECALL_WAIT;
            end
         end
         RECALL_WAIT:
         begin
            if (!mode)
               d.st = RECALL_IDLE;
            else if (trig)
            begin
               // A newer selection replaces the one in progress
               d.pending = preset_of(stable_n);
               d.cnt     = 32'h0000_0001;
            end
            else if (q.cnt >= 32'(RECALL_CYC))
            begin
               d.strobe  = 1'b1;
               d.last    = q.pending;
               d.st      = RECALL_IDLE;
               irq_set[IRQ_RECALL_BIT] = 1'b1;
            end
            else
               d.cnt = q.cnt + 32'h0000_0001;
         end
         default:
            d.st = RECALL_IDLE;
      endcase

      // Sticky events: setting beats a simultaneous clear
      d.irq_sts = (q.irq_sts & ~irq_clr) | irq_set;

      // Registered copies keep the status outputs free of decode glitches
      d.busy = (d.st == RECALL_WAIT);
      d.irq  = (d.irq_sts & d.irq_en) != 2'h0;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q          <= '0;
         q.fault_en <= FAULT_EN_RST;
         q.filt_len <= FILTER_LEN_RST;
         q.view     <= ALARM_NONE;
         q.irq_en   <= IRQ_EN_RST;
         q.prev_n   <= CODE_ALL_HIGH;
         q.st       <= RECALL_IDLE;
         q.alarm_n  <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_s_axi_awready = !q.aw_got && !q.bvalid;
   assign o_s_axi_wready  = !q.w_got && !q.bvalid;
   assign o_s_axi_bvalid  = q.bvalid;
   assign o_s_axi_bresp   = q.bresp;
   assign o_s_axi_arready = !q.rvalid;
   assign o_s_axi_rvalid  = q.rvalid;
   assign o_s_axi_rdata   = q.rdata;
   assign o_s_axi_rresp   = q.rresp;
   assign o_alarm_n       = q.alarm_n;
   assign o_recall_strobe = q.strobe;
   assign o_recall_preset = q.last;
   assign o_recall_busy   = q.busy;
   assign o_irq           = q.irq;

endmodule : gpi_preset_recall_alarm

// file: testbench/gpi_chk_sva.sv
/*
  Checker for the preset recall and fault alarm port.
  Assumes it is bound into the top module and sees only its ports.
*/
`timescale 1ns/1ps
module gpi_chk
   import gpi_pkg::*;
#(
   parameter int unsigned RECALL_CYC = 20
)
(
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic       i_general_purpose_input_port,
   input wire logic       o_alarm_n,
   input wire logic       o_recall_strobe,
   input wire logic [2:0] o_recall_preset,
   input wire logic       o_recall_busy,
   input wire logic       i_s_axi_awvalid,
   input wire logic       o_s_axi_awready,
   input wire logic       i_s_axi_wvalid,
   input wire logic       o_s_axi_wready,
   input wire logic       o_s_axi_bvalid,
   input wire logic       i_s_axi_bready,
   input wire logic [1:0] o_s_axi_bresp
);
   // ****************************************
   // Helper logic
   // ****************************************
   // Restarts keep busy high, so the run may exceed the recall time
   logic [31:0] busy_run_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         busy_run_q <= 32'h0;
      else
         busy_run_q <= o_recall_busy ? busy_run_q + 32'h1 : 32'h0;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   // ****************************************
   // Properties
   // ****************************************
   sequence s_busy_end;
      $past(o_recall_busy) && !o_recall_busy;
   endsequence
   sequence s_wr_both;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence

   property p_mode_off;
      !i_general_purpose_input_port |=> o_alarm_n && !o_recall_busy;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("port active while deselected");
   property p_busy_end;
      s_busy_end ##0 ($past(i_general_purpose_input_port)
         && i_general_purpose_input_port) |-> o_recall_strobe;
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("recall wait ended without strobe");
   property p_strobe_wait;
      o_recall_strobe |-> !o_recall_busy && busy_run_q >= RECALL_CYC;
   endproperty
   a_strobe_wait: assert property (p_strobe_wait)
      else $error("recall finished too early");
   property p_strobe_pulse;
      o_recall_strobe |=> !o_recall_strobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse)
      else $error("recall strobe longer than one cycle");
   property p_preset_hold;
      $changed(o_recall_preset) |-> o_recall_strobe && o_recall_preset != 3'h0;
   endproperty
   a_preset_hold: assert property (p_preset_hold)
      else $error("preset number changed without a recall");
   property p_alarm_held;
      !o_alarm_n && i_general_purpose_input_port && !o_s_axi_bvalid
         && !(i_s_axi_wvalid && o_s_axi_wready) |=> !o_alarm_n;
   endproperty
   a_alarm_held: assert property (p_alarm_held)
      else $error("alarm released without a command");
   property p_b_stand;
      o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
         && $stable(o_s_axi_bresp);
   endproperty
   a_b_stand: assert property (p_b_stand)
      else $error("write response dropped before taken");
   property p_wr_answer;
      s_wr_both |=> o_s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
endmodule : gpi_chk

// file: testbench/gpi_contacts.sv
/*
  Far-side model: three switch contacts, each pulled up when open.
  Assumes the bench commands which contacts close.
*/
`timescale 1ns/1ps
module gpi_contacts
(
   input  wire logic       i_ref_clk,
   input  wire logic [2:0] i_close,
   output logic      [2:0] o_pins_n
);
   initial o_pins_n = 3'h7;
   // Levels are held until commanded otherwise, never pulsed by us
   always @(posedge i_ref_clk)
      o_pins_n <= ~i_close;
endmodule : gpi_contacts

// file: testbench/testbench.sv
/*
  Self-checking bench: AXI4-Lite master, contact model, scoreboard.
  Assumes a 200 MHz clock and a shortened recall time.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   import gpi_pkg::*;
   localparam int unsigned RC = 20;
   logic        clk = 1'b0, rst_n = 1'b0, mode = 1'b1;
   fault_s      faults = '0, f;
   logic [2:0]  close = 3'h0, pins_n, preset;
   logic        alarm_n, strobe, busy, irq, awready, wready, bvalid;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        arready, rvalid;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [33:0] rd_q[$];
   logic [1:0]  wr_q[$];
   logic [2:0]  pr_q[$];
   int          errors = 0, check_count = 0, strobes = 0, i, seed = 32'hfdde;

   always #2.5 clk = ~clk;
   gpi_contacts gpi_contacts_i (.i_ref_clk(clk), .i_close(close),
      .o_pins_n(pins_n));
   gpi_preset_recall_alarm #(.RECALL_CYC(RC)) gpi_preset_recall_alarm_i (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_general_purpose_input_port(mode),
      .i_preset_sel_n(pins_n), .o_alarm_n(alarm_n), .i_faults(faults),
      .o_recall_strobe(strobe), .o_recall_preset(preset),
      .o_recall_busy(busy), .o_irq(irq), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp));

   // ****************************************
   // Scoreboard: an empty queue yields a value the design never gives
   // ****************************************
   // Each note is popped once, so a mismatch report cannot eat the next
   always @(posedge clk)
   begin
      logic [33:0] exp_rd;
      logic [2:0]  exp_pr;
      logic [1:0]  exp_wr;
      if (strobe)
      begin
         strobes++;
         if (pr_q.size() == 0) pr_q.push_back(3'h0);
         exp_pr = pr_q.pop_front();
         `CHK(preset, exp_pr)
      end
      if (rvalid && rready)
      begin
         if (rd_q.size() == 0) rd_q.push_back('1);
         exp_rd = rd_q.pop_front();
         `CHK({rresp, rdata}, exp_rd)
      end
      if (bvalid && bready)
      begin
         if (wr_q.size() == 0) wr_q.push_back(2'h1);
         exp_wr = wr_q.pop_front();
         `CHK(bresp, exp_wr)
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic tmo(input int n);
      if (n >= 200)
      begin
         errors++;
         give_verdict();
      end
   endtask : tmo

   // Response ready comes late on purpose, so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      n = 0;
      wr_q.push_back(r);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      do
      begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         bready <= n >= 2 && !(bvalid && bready);
      end while (!(bvalid && bready) && n < 200);
      tmo(n);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      rd_q.push_back(e);
      arvalid <= 1'b1;
      araddr <= a;
      do
      begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
         rready <= n >= 2 && !(rvalid && rready);
      end while (!(rvalid && rready) && n < 200);
      tmo(n);
   endtask : rd

   task automatic recall(input logic [2:0] p);
      int n, k;
      k = strobes;
      pr_q.push_back(p);
      close <= ~(3'h7 - p);
      for (n = 0; n < 200 && strobes == k; n++) @(posedge clk);
      tmo(n);
      `CHK(n >= RC, 1'b1)
      close <= 3'h0;
      repeat (10 + ($random(seed) & 7)) @(posedge clk);
   endtask : recall

   function automatic logic [31:0] stat(input logic [3:0] l,
                                         input logic [2:0] v);
      return (32'h7 << ST_INPUTS_LSB) | (32'h1 << ST_MODE_BIT)
         | (32'h7 << ST_LAST_LSB) | (32'(v) << ST_VIEW_LSB) | 32'(l);
   endfunction : stat

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
      rd(ADDR_FILTER_LEN, {RESP_OKAY, 16'h0, FILTER_LEN_RST});
      rd(ADDR_IRQ_ENABLE, {RESP_OKAY, 32'h0});
      rd(8'h1C, {RESP_SLVERR, 32'h0});
      rd(ADDR_ALARM_CMD, {RESP_OKAY, 32'h0});
      wr(ADDR_STATUS, 32'hFFFFFFFF, RESP_OKAY);
      wr(8'h1C, 32'hFFFFFFFF, RESP_SLVERR);
      wr(ADDR_FILTER_LEN, 32'h2, RESP_OKAY);
      wr(ADDR_IRQ_ENABLE, 32'h2, RESP_OKAY);
      for (i = 1; i < 8; i++) recall(3'(i));
      // One-cycle press is shorter than the filter and must be ignored
      close <= 3'h1;
      @(posedge clk);
      close <= 3'h0;
      repeat (30) @(posedge clk);
      `CHK(irq, 1'b0)
      rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h1});
      wr(ADDR_IRQ_ENABLE, 32'h3, RESP_OKAY);
      `CHK(irq, 1'b1)
      wr(ADDR_IRQ_CLEAR, 32'h1, RESP_OKAY);
      `CHK(irq, 1'b0)
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      for (i = 0; i < 4; i++)
      begin
         faults <= fault_s'(4'h1 << i);
         repeat (3) @(posedge clk);
         `CHK(alarm_n, 1'b0)
         faults <= '0;
         repeat (3) @(posedge clk);
         `CHK(alarm_n, 1'b0)
         wr(ADDR_ALARM_CMD, 32'h2, RESP_OKAY);
         rd(ADDR_STATUS, {RESP_OKAY, stat(4'h1 << i, 3'(i + 1))});
         wr(ADDR_ALARM_CMD, 32'h1, RESP_OKAY);
         rd(ADDR_STATUS, {RESP_OKAY, stat(4'h0, 3'(i + 1))});
         `CHK(alarm_n, 1'b1)
      end
      f = fault_s'(4'($random(seed)) | 4'h1);
      faults <= f;
      wr(ADDR_ALARM_CMD, 32'h1, RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK(alarm_n, 1'b0)
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      `CHK(alarm_n, 1'b1)
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      `CHK(alarm_n, 1'b0)
      // Drop the shared function in mid recall: the wait is abandoned
      close <= 3'h1;
      repeat (15) @(posedge clk);
      `CHK(busy, 1'b1)
      mode <= 1'b0;
      close <= 3'h7;
      repeat (40) @(posedge clk);
      `CHK(alarm_n, 1'b1)
      `CHK(busy, 1'b0)
      give_verdict();
   end
endmodule : testbench

bind gpi_preset_recall_alarm gpi_chk #(.RECALL_CYC(RECALL_CYC)) gpi_chk_i (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_general_purpose_input_port(i_general_purpose_input_port),
   .o_alarm_n(o_alarm_n), .o_recall_strobe(o_recall_strobe),
   .o_recall_preset(o_recall_preset), .o_recall_busy(o_recall_busy),
   .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
   .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
   .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
   .o_s_axi_bresp(o_s_axi_bresp));
